// [common/pmu_pkg.sv]
package pmu_pkg;

  // Register select codes on the register port
  localparam logic [6:0] REG_BASE_FIRST = 7'h00;
  localparam logic [6:0] REG_DESC_FIRST = 7'h30;
  localparam logic [6:0] REG_DESC_END = 7'h60;
  localparam logic [6:0] REG_STATUS = 7'h60;
  localparam logic [6:0] REG_SPACE_CTRL = 7'h61;

  // Page table geometry
  localparam int PAGE_ENTRIES = 48;
  localparam int VA_PAGE_LSB = 13;
  localparam int VA_BLOCK_LSB = 6;

  // Descriptor fields
  localparam int DESC_KEY_LSB = 0;
  localparam int DESC_DOWN_BIT = 3;
  localparam int DESC_DIRTY_BIT = 6;
  localparam int DESC_TOUCHED_BIT = 7;
  localparam int DESC_LEN_LSB = 8;
  localparam logic [15:0] DESC_STORE_MASK = 16'h7f0f;

  // Access keys
  localparam logic [2:0] KEY_NONRES = 3'h0;
  localparam logic [2:0] KEY_RO_TRAP = 3'h1;
  localparam logic [2:0] KEY_RO = 3'h2;
  localparam logic [2:0] KEY_UNUSED3 = 3'h3;
  localparam logic [2:0] KEY_RW_TRAP = 3'h4;
  localparam logic [2:0] KEY_RW_WTRAP = 3'h5;
  localparam logic [2:0] KEY_RW = 3'h6;
  localparam logic [2:0] KEY_UNUSED7 = 3'h7;

  // Processor mode codes
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL = 2'h2;
  localparam logic [1:0] MODE_USER = 2'h3;

  // Fault status fields
  localparam int ST_ENABLE_BIT = 0;
  localparam int ST_PAGE_LSB = 1;
  localparam int ST_SPACE_BIT = 4;
  localparam int ST_MODE_LSB = 5;
  localparam int ST_DONE_BIT = 7;
  localparam int ST_MAINT_BIT = 8;
  localparam int ST_TRAPEN_BIT = 9;
  localparam int ST_TRAP_BIT = 12;
  localparam int ST_RO_BIT = 13;
  localparam int ST_LEN_BIT = 14;
  localparam int ST_NONRES_BIT = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0080;
  localparam logic [15:0] STATUS_WMASK = 16'hf37f;

  // Space control bits per mode
  localparam int SC_USER_BIT = 0;
  localparam int SC_SUPER_BIT = 1;
  localparam int SC_KERNEL_BIT = 2;
  localparam logic [2:0] SPACE_CTRL_RESET = 3'h0;

  // Kernel virtual fault vector, 250 octal
  localparam logic [15:0] FAULT_VECTOR = 16'h00a8;

  typedef struct packed {
    logic [15:0] vaddr;
    logic [1:0] mode;
    logic write;
    logic ispace;
    logic dest;
  } acc_req_t;

  typedef struct packed {
    logic [21:0] phys;
    logic abort;
    logic trapCond;
  } acc_resp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LOOK = 2'b10
  } stage_t;

endpackage

// [src/page_word_array.sv]
`timescale 1ns/1ps
`default_nettype none

module page_word_array (
  input wire logic clock,          // System clock
  input wire logic arst_n,         // Async reset, active low
  input wire logic wrEn,           // Write strobe
  input wire logic [5:0] wrAddr,   // Write entry
  input wire logic [15:0] wrData,  // Write data
  input wire logic [5:0] rdAddrA,  // Read entry, port A
  output logic [15:0] rdDataA,     // Registered data, port A
  input wire logic [5:0] rdAddrB,  // Read entry, port B
  output logic [15:0] rdDataB      // Registered data, port B
);

  logic [15:0] words [0:47];

  ////////////////////////////////////////////////////////////////////////
  // Storage write
  always_ff @(posedge clock) begin
    if (wrEn) begin
      words[wrAddr] <= wrData;
    end
  end

  // Registered read ports
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdDataA <= 16'h0000;
      rdDataB <= 16'h0000;
    end else begin
      rdDataA <= words[rdAddrA];
      rdDataB <= words[rdAddrB];
    end
  end

endmodule

`default_nettype wire

// [src/paged_memory_protection_unit.sv]
// Behaviour
// - Three mode sets, I/D groups, page by VA[15:13]
// - I space for fetch class, else D space
// - Base register holds 16-bit physical block number
// - Decode three-bit access key into abort/trap
// - Aborted references suppressed; traps wait instruction end
// - Set touched on trap condition, dirty on write
// - Writing base or descriptor clears touched, dirty
// - Descriptor bit 3 selects downward growth
// - Length error versus seven-bit length field
// - Descriptor bits 15, 5, 4 read zero
// - Faults vector through kernel virtual 250
// - Status bit 0 enables relocation and checks
// - Status bits 15-13 freeze bits 1-7
// - Bit 15 on keys 0,3,7 or mode 2
// - Bit 14 on length error or mode 2
// - Bit 13 on write to key 1 or 2
// - Bit 12 on any trap condition
// - Bit 9 gates trap delivery, flags still log
// - Bit 8 relocates only destination references
// - Bit 7 read-only, instruction completed flag
// - Bits 6-5 record mode of faulting page
// - Bit 4 space, bits 3-1 page number
// - Status bits 11, 10 read zero
// - Physical address is base plus block, offset
// - Per-mode control bits enable data space
`timescale 1ns/1ps
`default_nettype none

module paged_memory_protection_unit (
  input wire logic clock,                  // 100 MHz system clock
  input wire logic arst_n,                 // Async reset, active low
  input wire logic accValidIn,             // Access request strobe
  input wire pmu_pkg::acc_req_t accReq,    // Access request fields
  output logic accReady,                   // Ready to take a request
  output logic accValid,                   // Answer strobe
  output pmu_pkg::acc_resp_t accResp,      // Answer fields
  input wire logic instrEnd,               // Instruction finished
  input wire logic instrSwTrap,            // Ended by software trap instr
  input wire logic cpuEventClear,          // Trace/parity/odd/timeout/irq
  output logic trapTake,                   // Deferred trap now due
  output logic [15:0] faultVector,         // Vector for abort and trap
  input wire logic regWrite,               // Register write strobe
  input wire logic regRead,                // Register read strobe
  input wire logic [6:0] regSel,           // Register select code
  input wire logic [15:0] regWdata,        // Register write data
  output logic regRvalid,                  // Read data strobe
  output logic [15:0] regRdata             // Read data
);

  ////////////////////////////////////////////////////////////////////////
  // State
  pmu_pkg::stage_t stage_reg;
  pmu_pkg::stage_t stage_next;
  pmu_pkg::acc_req_t req_reg;
  logic [5:0] lookIdx_reg;
  logic lookSpace_reg;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [2:0] spaceCtrl_reg;
  logic [47:0] touched_reg;
  logic [47:0] dirty_reg;
  logic trapPend_reg;
  logic trapPend_next;
  logic [6:0] rdSel_reg;
  logic [5:0] rdWord_reg;
  logic accReady_reg;
  logic accValid_reg;
  pmu_pkg::acc_resp_t accResp_reg;
  logic trapTake_reg;
  logic [15:0] faultVector_reg;
  logic regRvalid_reg;
  logic rdPend_reg;
  logic [15:0] regRdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Software register decode
  logic selBase;
  logic selDesc;
  logic selStatus;
  logic selCtrl;
  logic [6:0] descOff;
  logic [5:0] swWord;
  logic wrBase;
  logic wrDesc;

  assign selBase = (regSel < pmu_pkg::REG_DESC_FIRST);
  assign selDesc = (regSel >= pmu_pkg::REG_DESC_FIRST) &&
                   (regSel < pmu_pkg::REG_DESC_END);
  assign selStatus = (regSel == pmu_pkg::REG_STATUS);
  assign selCtrl = (regSel == pmu_pkg::REG_SPACE_CTRL);
  assign descOff = regSel - pmu_pkg::REG_DESC_FIRST;
  assign swWord = selBase ? regSel[5:0] : descOff[5:0];
  assign wrBase = regWrite && selBase;
  assign wrDesc = regWrite && selDesc;

  ////////////////////////////////////////////////////////////////////////
  // Entry select for an incoming access
  logic takeReq;
  logic [1:0] setCode;
  logic dsEnMode;
  logic useDspace;
  logic [5:0] transIdx;

  assign takeReq = accValidIn && (stage_reg == pmu_pkg::ST_IDLE);
  // Kernel, supervisor, user sets at entries 0, 16, 32
  assign setCode = {accReq.mode == pmu_pkg::MODE_USER,
                    accReq.mode == pmu_pkg::MODE_SUPER};
  // Data space enable per mode
  assign dsEnMode =
    (accReq.mode == pmu_pkg::MODE_USER) ?
      spaceCtrl_reg[pmu_pkg::SC_USER_BIT] :
    (accReq.mode == pmu_pkg::MODE_SUPER) ?
      spaceCtrl_reg[pmu_pkg::SC_SUPER_BIT] :
    (accReq.mode == pmu_pkg::MODE_KERNEL) ?
      spaceCtrl_reg[pmu_pkg::SC_KERNEL_BIT] : 1'b0;
  assign useDspace = !accReq.ispace && dsEnMode;
  assign transIdx = {setCode, useDspace,
                     accReq.vaddr[15:pmu_pkg::VA_PAGE_LSB]};

  ////////////////////////////////////////////////////////////////////////
  // Base and descriptor storage
  logic [15:0] baseLook;
  logic [15:0] baseSw;
  logic [15:0] descLook;
  logic [15:0] descSw;

  page_word_array baseArray (
    .clock(clock),
    .arst_n(arst_n),
    .wrEn(wrBase),
    .wrAddr(swWord),
    .wrData(regWdata),
    .rdAddrA(transIdx),
    .rdDataA(baseLook),
    .rdAddrB(swWord),
    .rdDataB(baseSw)
  );

  page_word_array descArray (
    .clock(clock),
    .arst_n(arst_n),
    .wrEn(wrDesc),
    .wrAddr(swWord),
    .wrData(regWdata & pmu_pkg::DESC_STORE_MASK),
    .rdAddrA(transIdx),
    .rdDataA(descLook),
    .rdAddrB(swWord),
    .rdDataB(descSw)
  );

  ////////////////////////////////////////////////////////////////////////
  // Access key, length and mode checks
  logic [2:0] key;
  logic [6:0] blockNum;
  logic [6:0] lenField;
  logic growDown;
  logic lookNow;
  logic relocate;
  logic modeIllegal;
  logic keyNonRes;
  logic keyReadOnly;
  logic keyTrap;
  logic lenErr;
  logic errNonRes;
  logic errLen;
  logic errRo;
  logic doAbort;
  logic trapCond;
  logic [15:0] physBlock;
  logic [21:0] physAddr;

  assign key = descLook[pmu_pkg::DESC_KEY_LSB +: 3];
  assign blockNum = req_reg.vaddr[12:pmu_pkg::VA_BLOCK_LSB];
  assign lenField = descLook[pmu_pkg::DESC_LEN_LSB +: 7];
  assign growDown = descLook[pmu_pkg::DESC_DOWN_BIT];
  assign lookNow = (stage_reg == pmu_pkg::ST_LOOK);
  // Maintenance mode relocates destination references only
  assign relocate = status_reg[pmu_pkg::ST_ENABLE_BIT] &&
                    (!status_reg[pmu_pkg::ST_MAINT_BIT] ||
                     req_reg.dest);
  assign modeIllegal = (req_reg.mode == pmu_pkg::MODE_ILLEGAL);
  assign keyNonRes = (key == pmu_pkg::KEY_NONRES) ||
                     (key == pmu_pkg::KEY_UNUSED3) ||
                     (key == pmu_pkg::KEY_UNUSED7);
  assign keyReadOnly = (key == pmu_pkg::KEY_RO_TRAP) ||
                       (key == pmu_pkg::KEY_RO);
  assign keyTrap = req_reg.write ?
    ((key == pmu_pkg::KEY_RW_TRAP) || (key == pmu_pkg::KEY_RW_WTRAP)) :
    ((key == pmu_pkg::KEY_RO_TRAP) || (key == pmu_pkg::KEY_RW_TRAP));
  // Upward pages end at the field, downward pages start there
  assign lenErr = growDown ? (blockNum < lenField) :
                             (blockNum > lenField);
  assign errNonRes = relocate && (keyNonRes || modeIllegal);
  assign errLen = relocate && (lenErr || modeIllegal);
  assign errRo = relocate && req_reg.write && keyReadOnly;
  assign doAbort = errNonRes || errLen || errRo;
  assign trapCond = relocate && keyTrap && !doAbort;
  assign physBlock = baseLook + {9'h000, blockNum};
  assign physAddr = relocate ?
    {physBlock, req_reg.vaddr[5:0]} : {6'h00, req_reg.vaddr};

  ////////////////////////////////////////////////////////////////////////
  // Touched and dirty flags per entry
  genvar e;
  generate
    for (e = 0; e < pmu_pkg::PAGE_ENTRIES; e = e + 1) begin : gFlags
      logic hit;
      logic swClr;
      assign hit = lookNow && (lookIdx_reg == 6'(e));
      assign swClr = (wrBase || wrDesc) && (swWord == 6'(e));
      // Hardware set wins over a same-cycle software clear
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          touched_reg[e] <= 1'b0;
          dirty_reg[e] <= 1'b0;
        end else begin
          touched_reg[e] <= (hit && trapCond) ||
                            (touched_reg[e] && !swClr);
          dirty_reg[e] <= (hit && relocate && req_reg.write && !doAbort) ||
                          (dirty_reg[e] && !swClr);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Fault status next value
  logic frozen;
  logic faultLog;
  logic [5:0] faultInfo;

  assign frozen = |status_reg[pmu_pkg::ST_NONRES_BIT:pmu_pkg::ST_RO_BIT];
  assign faultLog = lookNow && !frozen && (doAbort || trapCond);
  assign faultInfo = {req_reg.mode, lookSpace_reg,
                      req_reg.vaddr[15:pmu_pkg::VA_PAGE_LSB]};

  always_comb begin
    status_next = status_reg;
    if (regWrite && selStatus) begin
      status_next = (regWdata & pmu_pkg::STATUS_WMASK) |
                    (status_reg & ~pmu_pkg::STATUS_WMASK);
    end
    if (!frozen && instrEnd && !instrSwTrap) begin
      status_next[pmu_pkg::ST_DONE_BIT] = 1'b1;
    end
    if (!frozen && cpuEventClear) begin
      status_next[pmu_pkg::ST_DONE_BIT] = 1'b0;
    end
    if (faultLog) begin
      status_next[pmu_pkg::ST_PAGE_LSB +: 6] = faultInfo;
      status_next[pmu_pkg::ST_NONRES_BIT] |= errNonRes;
      status_next[pmu_pkg::ST_LEN_BIT] |= errLen;
      status_next[pmu_pkg::ST_RO_BIT] |= errRo;
      status_next[pmu_pkg::ST_TRAP_BIT] |= trapCond;
    end
  end

  // Deferred trap: latched at the condition, due at instruction end
  assign trapPend_next = (lookNow && trapCond &&
                          status_reg[pmu_pkg::ST_TRAPEN_BIT]) ||
                         (trapPend_reg && !instrEnd);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= pmu_pkg::STATUS_RESET;
      spaceCtrl_reg <= pmu_pkg::SPACE_CTRL_RESET;
      trapPend_reg <= 1'b0;
      trapTake_reg <= 1'b0;
      faultVector_reg <= pmu_pkg::FAULT_VECTOR;
    end else begin
      status_reg <= status_next;
      if (regWrite && selCtrl) begin
        spaceCtrl_reg <= regWdata[2:0];
      end
      trapPend_reg <= trapPend_next;
      trapTake_reg <= instrEnd && trapPend_reg;
      faultVector_reg <= pmu_pkg::FAULT_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access pipeline: take, look up, answer
  always_comb begin
    case (stage_reg)
      pmu_pkg::ST_IDLE: stage_next = takeReq ? pmu_pkg::ST_LOOK :
                                               pmu_pkg::ST_IDLE;
      pmu_pkg::ST_LOOK: stage_next = pmu_pkg::ST_IDLE;
      default: stage_next = pmu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= pmu_pkg::ST_IDLE;
      req_reg <= '0;
      lookIdx_reg <= 6'h00;
      lookSpace_reg <= 1'b0;
      accReady_reg <= 1'b1;
    end else begin
      stage_reg <= stage_next;
      accReady_reg <= (stage_next == pmu_pkg::ST_IDLE);
      if (takeReq) begin
        req_reg <= accReq;
        lookIdx_reg <= transIdx;
        lookSpace_reg <= useDspace;
      end
    end
  end

  // Answer registers; abort is flagged, completion still strobes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      accValid_reg <= 1'b0;
      accResp_reg <= '0;
    end else begin
      accValid_reg <= lookNow;
      if (lookNow) begin
        accResp_reg.phys <= physAddr;
        accResp_reg.abort <= doAbort;
        accResp_reg.trapCond <= trapCond;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read path
  logic [15:0] descView;
  logic [15:0] rdMux;

  assign descView = (descSw & pmu_pkg::DESC_STORE_MASK) |
                    {8'h00, touched_reg[rdWord_reg],
                     dirty_reg[rdWord_reg], 6'h00};
  assign rdMux =
    (rdSel_reg < pmu_pkg::REG_DESC_FIRST) ? baseSw :
    (rdSel_reg < pmu_pkg::REG_DESC_END) ? descView :
    (rdSel_reg == pmu_pkg::REG_STATUS) ? status_reg :
    (rdSel_reg == pmu_pkg::REG_SPACE_CTRL) ? {13'h0000, spaceCtrl_reg} :
    16'h0000;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdSel_reg <= 7'h7f;
      rdWord_reg <= 6'h00;
      rdPend_reg <= 1'b0;
      regRvalid_reg <= 1'b0;
      regRdata_reg <= 16'h0000;
    end else begin
      if (regRead) begin
        rdSel_reg <= regSel;
        rdWord_reg <= swWord;
      end
      rdPend_reg <= regRead;
      regRvalid_reg <= rdPend_reg; // Strobe waits for storage read
      if (rdPend_reg) begin
        regRdata_reg <= rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign accReady = accReady_reg;
  assign accValid = accValid_reg;
  assign accResp = accResp_reg;
  assign trapTake = trapTake_reg;
  assign faultVector = faultVector_reg;
  assign regRvalid = regRvalid_reg;
  assign regRdata = regRdata_reg;

endmodule

`default_nettype wire

// [testbench/core_access_model.sv]
`timescale 1ns/1ps
`default_nettype none

module core_access_model (
  input wire logic clock,                   // System clock
  output var logic accValidIn,              // Request strobe
  output var pmu_pkg::acc_req_t accReq,     // Request fields
  input wire logic accReady,                // Unit can take a request
  input wire logic accValid,                // Answer strobe
  input wire pmu_pkg::acc_resp_t accResp    // Answer fields
);
  initial begin
    accValidIn = 1'b0;
    accReq = '0;
  end

  // One reference: hold until taken, then wait for the answer
  task automatic access(input pmu_pkg::acc_req_t r,
      output pmu_pkg::acc_resp_t rs, output logic ok);
    int n;
    @(posedge clock);
    accValidIn <= 1'b1;
    accReq <= r;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (accReady !== 1'b1 && n < 16);
    accValidIn <= 1'b0;
    accReq <= ~r;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (accValid !== 1'b1 && n < 16);
    ok = (accValid === 1'b1);
    rs = accResp;
  endtask
endmodule

`default_nettype wire

// [testbench/paged_memory_protection_unit_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module paged_memory_protection_unit_sva (
  input wire logic clock,                  // System clock
  input wire logic arst_n,                 // Async reset, active low
  input wire logic accValidIn,             // Request strobe
  input wire pmu_pkg::acc_req_t accReq,    // Request fields
  input wire logic accReady,               // Ready to take
  input wire logic accValid,               // Answer strobe
  input wire pmu_pkg::acc_resp_t accResp,  // Answer fields
  input wire logic instrEnd,               // Instruction finished
  input wire logic trapTake,               // Trap due
  input wire logic [15:0] faultVector,     // Fault vector
  input wire logic regWrite,               // Register write
  input wire logic regRead,                // Register read
  input wire logic [6:0] regSel,           // Register select
  input wire logic [15:0] regWdata,        // Write data
  input wire logic regRvalid,              // Read data strobe
  input wire logic [15:0] regRdata         // Read data
);
  logic relocOn_reg;
  logic maint_reg;
  logic take;

  // Request accepted
  assign take = accValidIn && accReady;

  // Shadow of software enable and maintenance bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      relocOn_reg <= 1'b0;
      maint_reg <= 1'b0;
    end else if (regWrite && regSel == pmu_pkg::REG_STATUS) begin
      relocOn_reg <= regWdata[pmu_pkg::ST_ENABLE_BIT];
      maint_reg <= regWdata[pmu_pkg::ST_MAINT_BIT];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  take_answer_a: assert property (
    take |=> !accReady ##1 (accValid && accReady))
    else $error("answer not two cycles after take");
  flat_off_a: assert property (
    take && !relocOn_reg |-> ##2 !accResp.abort &&
    accResp.phys == {6'h00, $past(accReq.vaddr, 2)})
    else $error("unrelocated address changed");
  maint_flat_a: assert property (
    take && relocOn_reg && maint_reg && !accReq.dest |-> ##2
    accResp.phys == {6'h00, $past(accReq.vaddr, 2)})
    else $error("non-destination reference relocated");
  mode_two_a: assert property (
    take && relocOn_reg && (!maint_reg || accReq.dest) &&
    accReq.mode == pmu_pkg::MODE_ILLEGAL |-> ##2 accValid && accResp.abort)
    else $error("illegal mode not aborted");
  abort_only_a: assert property (
    accValid && accResp.abort |-> !accResp.trapCond)
    else $error("trap reported with abort");
  trap_end_a: assert property (
    trapTake |-> $past(instrEnd) && !$past(trapTake))
    else $error("trap not after instruction end");
  vector_a: assert property (
    faultVector == pmu_pkg::FAULT_VECTOR)
    else $error("fault vector wrong");
  desc_spare_a: assert property (
    regRvalid && $past(regRead, 2) &&
    $past(regSel, 2) >= pmu_pkg::REG_DESC_FIRST &&
    $past(regSel, 2) < pmu_pkg::REG_DESC_END |-> regRdata[15] == 1'b0 &&
    regRdata[5:4] == 2'h0)
    else $error("descriptor spare bits set");
  status_spare_a: assert property (
    regRvalid && $past(regRead, 2) && $past(regSel, 2) ==
    pmu_pkg::REG_STATUS |-> regRdata[11:10] == 2'h0)
    else $error("status spare bits set");
endmodule

bind paged_memory_protection_unit paged_memory_protection_unit_sva u_sva (
  .clock, .arst_n, .accValidIn, .accReq, .accReady, .accValid, .accResp,
  .instrEnd, .trapTake, .faultVector, .regWrite, .regRead, .regSel,
  .regWdata, .regRvalid, .regRdata);

`default_nettype wire

// [testbench/paged_memory_protection_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module paged_memory_protection_unit_tb;
  typedef struct packed {
    logic [15:0] desc;
    logic [15:0] va;
    logic wr;
    logic ab;
    logic tr;
    logic [3:0] err;
  } row_t;
  logic clock, arst_n, accValidIn, accReady, accValid, instrEnd, ok;
  logic instrSwTrap, cpuEventClear, trapTake, regWrite, regRead, regRvalid;
  pmu_pkg::acc_req_t accReq;
  pmu_pkg::acc_resp_t accResp, resp;
  logic [6:0] regSel;
  logic [15:0] faultVector, regWdata, regRdata, rd, exp;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  localparam logic [6:0] STAT = pmu_pkg::REG_STATUS;
  localparam logic [1:0] KERN = pmu_pkg::MODE_KERNEL;
  // Kernel I-space references: descriptor, address, write, outcome, flags
  row_t rows [17] = '{
    '{16'h7f00, 16'h2040, 1'b0, 1'b1, 1'b0, 4'h8},
    '{16'h7f01, 16'h4045, 1'b0, 1'b0, 1'b1, 4'h1},
    '{16'h7f01, 16'h6046, 1'b1, 1'b1, 1'b0, 4'h2},
    '{16'h7f02, 16'h8047, 1'b0, 1'b0, 1'b0, 4'h0},
    '{16'h7f02, 16'ha048, 1'b1, 1'b1, 1'b0, 4'h2},
    '{16'h7f03, 16'hc049, 1'b0, 1'b1, 1'b0, 4'h8},
    '{16'h7f04, 16'he04a, 1'b1, 1'b0, 1'b1, 4'h1},
    '{16'h7f04, 16'h004b, 1'b0, 1'b0, 1'b1, 4'h1},
    '{16'h7f05, 16'h204c, 1'b0, 1'b0, 1'b0, 4'h0},
    '{16'h7f05, 16'h404d, 1'b1, 1'b0, 1'b1, 4'h1},
    '{16'h7f06, 16'h604e, 1'b1, 1'b0, 1'b0, 4'h0},
    '{16'h7f07, 16'h804f, 1'b1, 1'b1, 1'b0, 4'h8},
    '{16'h0206, 16'ha0c0, 1'b0, 1'b1, 1'b0, 4'h4},
    '{16'h0206, 16'ha080, 1'b1, 1'b0, 1'b0, 4'h0},
    '{16'h7e0e, 16'hff40, 1'b0, 1'b1, 1'b0, 4'h4},
    '{16'h7e0e, 16'hff80, 1'b0, 1'b0, 1'b0, 4'h0},
    '{16'h0200, 16'hc0c0, 1'b1, 1'b1, 1'b0, 4'hc}};

  paged_memory_protection_unit u_paged_memory_protection_unit (
    .clock, .arst_n, .accValidIn, .accReq, .accReady, .accValid, .accResp,
    .instrEnd, .instrSwTrap, .cpuEventClear, .trapTake, .faultVector,
    .regWrite, .regRead, .regSel, .regWdata, .regRvalid, .regRdata);
  core_access_model u_core_access_model (
    .clock, .accValidIn, .accReq, .accReady, .accValid, .accResp);

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [21:0] g, e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic acc(input pmu_pkg::acc_req_t r);
    u_core_access_model.access(r, resp, ok);
    if (!ok) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic reg_wr(input logic [6:0] s, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regSel <= s;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic reg_rd(input logic [6:0] s, output logic [15:0] d);
    int k;
    @(posedge clock);
    regRead <= 1'b1;
    regSel <= s;
    @(posedge clock);
    regRead <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (regRvalid !== 1'b1 && k < 8);
    if (regRvalid !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    d = regRdata;
  endtask

  // Pulse instruction end, count trap pulses
  task automatic end_instr(input logic sw, output int cnt);
    @(posedge clock);
    instrEnd <= 1'b1;
    instrSwTrap <= sw;
    @(posedge clock);
    instrEnd <= 1'b0;
    cnt = 0;
    repeat (4) begin
      @(posedge clock);
      if (trapTake === 1'b1) cnt++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    {instrEnd, instrSwTrap, cpuEventClear, regWrite, regRead} = '0;
    regSel = '0;
    regWdata = '0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    reg_rd(STAT, rd);
    chk("status reset", 22'(rd), 22'h80);
    reg_rd(pmu_pkg::REG_SPACE_CTRL, rd);
    chk("space ctrl reset", 22'(rd), 22'h0);
    chk("vector", 22'(faultVector), 22'ha8);
    foreach (rows[i]) begin
      reg_wr(STAT, 16'h0001);
      reg_wr(7'(rows[i].va[15:13]), 16'h1230);
      reg_wr(7'h30 + 7'(rows[i].va[15:13]), rows[i].desc);
      acc({rows[i].va, KERN, rows[i].wr, 2'b10});
      chk("outcome", 22'({resp.abort, resp.trapCond}),
        22'({rows[i].ab, rows[i].tr}));
      if (!rows[i].ab)
        chk("phys", resp.phys,
          {16'h1230 + 16'(rows[i].va[12:6]), rows[i].va[5:0]});
      reg_rd(STAT, rd);
      exp = {rows[i].err, 12'h081};
      if (rows[i].err != 4'h0) exp[3:1] = rows[i].va[15:13];
      chk("status", 22'(rd), 22'(exp));
      reg_rd(7'h30 + 7'(rows[i].va[15:13]), rd);
      exp = (rows[i].desc & pmu_pkg::DESC_STORE_MASK) |
        {8'h00, rows[i].tr, rows[i].wr && !rows[i].ab, 6'h00};
      chk("descriptor", 22'(rd), 22'(exp));
    end
    // Relocation off, maintenance mode, illegal mode
    reg_wr(STAT, 16'h0000);
    acc({16'h2040, KERN, 3'b010});
    chk("flat", resp.phys, 22'h2040);
    reg_wr(STAT, 16'h0101);
    acc({16'ha080, KERN, 3'b010});
    chk("maint flat", resp.phys, 22'ha080);
    acc({16'ha080, KERN, 3'b011});
    chk("maint dest", resp.phys, {16'h1232, 6'h00});
    reg_wr(STAT, 16'h0001);
    acc({16'h2040, pmu_pkg::MODE_ILLEGAL, 3'b010});
    reg_rd(STAT, rd);
    chk("illegal mode", 22'(rd), 22'hc0c3);
    // Data space for kernel, user set through I space
    reg_wr(pmu_pkg::REG_SPACE_CTRL, 16'h0004);
    reg_wr(7'h09, 16'h2000);
    reg_wr(7'h39, 16'h7f06);
    reg_wr(7'h21, 16'h3000);
    reg_wr(7'h51, 16'h7f06);
    acc({16'h2040, KERN, 3'b100});
    chk("kernel D", resp.phys, {16'h2001, 6'h00});
    reg_rd(7'h39, rd);
    chk("dirty", 22'(rd), 22'h7f46);
    reg_wr(7'h09, 16'h2000);
    reg_rd(7'h39, rd);
    chk("flags cleared", 22'(rd), 22'h7f06);
    acc({16'h2040, pmu_pkg::MODE_USER, 3'b000});
    chk("user I", resp.phys, {16'h3001, 6'h00});
    // Freeze, spare and read-only bits, unmapped select
    reg_wr(STAT, 16'h8001);
    acc({16'h2040, pmu_pkg::MODE_ILLEGAL, 3'b010});
    reg_rd(STAT, rd);
    chk("frozen", 22'(rd), 22'h8081);
    reg_wr(STAT, 16'hffff);
    reg_rd(STAT, rd);
    chk("status write", 22'(rd), 22'hf3ff);
    reg_wr(7'h39, 16'hffff);
    reg_rd(7'h39, rd);
    chk("desc write", 22'(rd), 22'h7f0f);
    reg_rd(7'h7f, rd);
    chk("unmapped", 22'(rd), 22'h0);
    // Deferred trap, enabled then disabled
    reg_wr(7'h39, 16'h7f04);
    reg_wr(STAT, 16'h0201);
    acc({16'h2040, KERN, 3'b100});
    end_instr(1'b0, n);
    chk("trap taken", 22'(n), 22'h1);
    reg_wr(STAT, 16'h0001);
    acc({16'h2040, KERN, 3'b100});
    end_instr(1'b0, n);
    chk("trap gated", 22'(n), 22'h0);
    // Completion flag
    @(posedge clock);
    cpuEventClear <= 1'b1;
    @(posedge clock);
    cpuEventClear <= 1'b0;
    reg_rd(STAT, rd);
    chk("done cleared", 22'(rd[7]), 22'h0);
    end_instr(1'b1, n);
    reg_rd(STAT, rd);
    chk("done sw trap", 22'(rd[7]), 22'h0);
    end_instr(1'b0, n);
    reg_rd(STAT, rd);
    chk("done set", 22'(rd[7]), 22'h1);
    report_and_stop();
  end
endmodule

`default_nettype wire
